/* File: rtl/mdc_defines.vh */
// constants for the metering datapath control register and its fields
// assumes inclusion by bare name from the rtl and verif files
`ifndef MDC_DEFINES_VH
`define MDC_DEFINES_VH

// register address on the host register port
`define MDC_ADDR_W 12
`define MDC_CTRL_OFFSET 12'h060
`define MDC_CTRL_RESET 32'h00000000
// writable bits [13:3]; [31:14] and [2:0] read as zero here
`define MDC_CTRL_WMASK 32'h00003FF8

// field positions
`define MDC_BIT_REACT_LPF_BYP 13
`define MDC_BIT_ACT_LPF_BYP 12
`define MDC_BIT_NEUT_INT_EN 11
`define MDC_BIT_VNOM_C 10
`define MDC_BIT_VNOM_B 9
`define MDC_BIT_VNOM_A 8
`define MDC_BIT_RMS_SRC 7
`define MDC_BIT_ZX_SRC 6
`define MDC_BIT_PH_INT_EN 5
`define MDC_BIT_MT_EN 4
`define MDC_BIT_HPF_DIS 3

// multipoint compensation
`define MDC_MT_REGIONS 6
`define MDC_MT_OFF_CODE 4'hF

`endif

/* File: rtl/mdc_mt_region.v */
// multipoint gain region tracker for one current channel
// assumes rms and thresholds are steady between rms updates
`default_nettype none
`include "mdc_defines.vh"

module mdc_mt_region #(
    parameter RW = 24,
    parameter GW = 24
) (
    // clock and reset
    input wire clock,
    input wire srst,
    // control
    input wire enable,
    // measurement and programmed values
    input wire [RW-1:0] rms,
    input wire [5*RW-1:0] low_thr,
    input wire [5*RW-1:0] high_thr,
    input wire [6*GW-1:0] gain_tab,
    // results
    output reg [3:0] region_r,
    output reg [GW-1:0] gain_r
);

    reg [2:0] idx_r;
    reg [2:0] idx_nxt;

    // step one region at a time; low/high gap gives hysteresis against chatter
    always @* begin
        idx_nxt = idx_r;
        if (!enable) begin
            idx_nxt = 3'h0;
        end else if (idx_r < 3'h5 && rms > high_thr[idx_r*RW +: RW]) begin
            idx_nxt = idx_r + 3'h1;
        end else if (idx_r > 3'h0 && rms < low_thr[(idx_r-3'h1)*RW +: RW]) begin
            idx_nxt = idx_r - 3'h1;
        end
    end

    // region code and selected gain, off code while disabled
    always @(posedge clock) begin
        if (srst) begin
            idx_r <= 3'h0;
            region_r <= `MDC_MT_OFF_CODE;
            gain_r <= {GW{1'b0}};
        end else begin
            idx_r <= idx_nxt;
            region_r <= enable ? {1'b0, idx_nxt} : `MDC_MT_OFF_CODE;
            gain_r <= enable ? gain_tab[idx_nxt*GW +: GW] : {GW{1'b0}};
        end
    end

endmodule

`default_nettype wire

/* File: rtl/mdc_top.v */
// metering datapath control register and the datapath selects it steers
// assumes a host port decoder delivering word writes and reads, one clock
`default_nettype none
`include "mdc_defines.vh"

// Behaviour
// - bit 13 set bypasses low-pass filter in total reactive power path
// - bit 12 set bypasses low-pass filter in total active power path
// - bit 11 set enables the neutral current integrator
// - bits 8,9,10 pick nominal voltage for phase A,B,C apparent power
// - bit 7 zero feeds rms calculations with compensated current samples
// - bit 6 picks zero-crossing input: zero after stages, one before them
// - bit 5 enables the three phase integrators, not the neutral one
// - bit 4 enables multipoint phase and gain compensation
// - bit 3 disables all voltage and current high-pass filters
module mdc_top #(
    parameter SW = 24,
    parameter RW = 24,
    parameter GW = 24
) (
    // clock and reset
    input wire clock,
    input wire srst,
    // host register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [`MDC_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata_r,
    output reg reg_rvalid_r,
    // phase samples a,b,c packed low to high
    input wire [3*SW-1:0] raw_current,
    input wire [3*SW-1:0] compensated_current_waveform,
    input wire [3*SW-1:0] raw_zx_data,
    input wire [3*SW-1:0] compensated_zx_data,
    input wire [3*RW-1:0] measured_voltage_rms,
    input wire [RW-1:0] nominal_voltage_constant,
    // multipoint programmed values and rms per phase
    input wire [3*RW-1:0] current_rms_amplitude,
    input wire [15*RW-1:0] multipoint_low_threshold,
    input wire [15*RW-1:0] multipoint_high_threshold,
    input wire [18*GW-1:0] multipoint_gain_factor,
    // control levels to the datapath
    output reg reactive_power_lowpass_bypass,
    output reg active_power_lowpass_bypass,
    output reg neutral_integrator_enable,
    output reg phase_integrator_enable,
    output reg highpass_disable_all,
    output reg multipoint_compensation_enable,
    // selected datapath values
    output reg [3*SW-1:0] rms_sample_r,
    output reg [3*SW-1:0] zx_sample_r,
    output reg [3*RW-1:0] apparent_power_voltage_r,
    output wire [3*GW-1:0] multipoint_gain_r,
    output wire [12-1:0] multipoint_region_r
);

    reg [31:0] ctrl_r;
    reg [31:0] ctrl_nxt;
    wire phase_a_nominal_voltage_select;
    wire phase_b_nominal_voltage_select;
    wire phase_c_nominal_voltage_select;
    wire rms_sample_source_select;
    wire zero_cross_source_select;
    wire [2:0] vnom_sel;

    // timing plan: a write lands in ctrl_r at its strobe edge, the control
    // levels and selects follow one edge later, so all steered outputs move
    // together two edges after the write; the trackers read ctrl_r directly
    // and so switch on that same edge as the levels
    // limitation: a select flips on a clock edge, not on a sample boundary,
    // so software should change it only while the affected result is unused
    // the extra flop costs one cycle but keeps host decode off datapath timing

    // field map of ctrl_r, all fields plain read/write, reset zero:
    //   13 reactive power low-pass bypass
    //   12 active power low-pass bypass
    //   11 neutral integrator enable
    //   10..8 nominal voltage select, phase c..a
    //   7 rms sample source, 6 zero-cross source
    //   5 phase integrator enable, 4 multipoint enable
    //   3 high-pass disable for every channel
    //   31:14 and 2:0 reserved: not stored, read as zero

    // address match shared by read and write paths
    function hit_ctrl;
        input [`MDC_ADDR_W-1:0] a;
        begin
            hit_ctrl = (a == `MDC_CTRL_OFFSET);
        end
    endfunction

    // only documented fields store; reserved bits never take a write
    // other addresses leave ctrl_r untouched; the port moves whole words
    // only, so there is no byte lane to merge
    always @* begin
        ctrl_nxt = ctrl_r;
        if (reg_wr && hit_ctrl(reg_addr)) begin
            ctrl_nxt = reg_wdata & `MDC_CTRL_WMASK;
        end
    end

    // named taps of the stored fields; vnom_sel packs them a,b,c low to high
    // to match the phase order of the sample buses
    assign phase_a_nominal_voltage_select = ctrl_r[`MDC_BIT_VNOM_A];
    assign phase_b_nominal_voltage_select = ctrl_r[`MDC_BIT_VNOM_B];
    assign phase_c_nominal_voltage_select = ctrl_r[`MDC_BIT_VNOM_C];
    assign rms_sample_source_select = ctrl_r[`MDC_BIT_RMS_SRC];
    assign zero_cross_source_select = ctrl_r[`MDC_BIT_ZX_SRC];
    assign vnom_sel = {phase_c_nominal_voltage_select, phase_b_nominal_voltage_select,
                       phase_a_nominal_voltage_select};

    // register storage and read answer one cycle after the strobe
    // a read in the same cycle as a write returns the old word, which keeps
    // the read path free of the write data mux
    always @(posedge clock) begin
        if (srst) begin
            ctrl_r <= `MDC_CTRL_RESET;
            reg_rdata_r <= 32'h00000000;
            reg_rvalid_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            reg_rvalid_r <= reg_rd;
            // unmapped reads answer zero rather than stale data, so a
            // mistyped address cannot pass for a valid setting
            reg_rdata_r <= (reg_rd && hit_ctrl(reg_addr)) ? ctrl_r : 32'h00000000;
        end
    end

    // control levels, one flop behind the register
    // each level is a plain copy of its field so the datapath sees a clean
    // registered enable; the extra flop keeps the host port decode off the
    // long paths into the filters and integrators
    // the neutral integrator keeps its own enable apart from the phase ones
    always @(posedge clock) begin
        if (srst) begin
            reactive_power_lowpass_bypass <= 1'b0;
            active_power_lowpass_bypass <= 1'b0;
            neutral_integrator_enable <= 1'b0;
            phase_integrator_enable <= 1'b0;
            highpass_disable_all <= 1'b0;
            multipoint_compensation_enable <= 1'b0;
        end else begin
            reactive_power_lowpass_bypass <= ctrl_r[`MDC_BIT_REACT_LPF_BYP];
            active_power_lowpass_bypass <= ctrl_r[`MDC_BIT_ACT_LPF_BYP];
            neutral_integrator_enable <= ctrl_r[`MDC_BIT_NEUT_INT_EN];
            phase_integrator_enable <= ctrl_r[`MDC_BIT_PH_INT_EN];
            highpass_disable_all <= ctrl_r[`MDC_BIT_HPF_DIS];
            multipoint_compensation_enable <= ctrl_r[`MDC_BIT_MT_EN];
        end
    end

    // per-phase selects and multipoint trackers
    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1) begin : g_phase
            // rms source: the raw tap skips the high-pass filter and integrator,
            // handy for checking their settings against the unfiltered current
            always @(posedge clock) begin
                if (srst) begin
                    rms_sample_r[p*SW +: SW] <= {SW{1'b0}};
                end else if (rms_sample_source_select) begin
                    rms_sample_r[p*SW +: SW] <= raw_current[p*SW +: SW];
                end else begin
                    rms_sample_r[p*SW +: SW] <= compensated_current_waveform[p*SW +: SW];
                end
            end

            // zero-cross source: before or after high-pass, integrator and phase fix
            always @(posedge clock) begin
                if (srst) begin
                    zx_sample_r[p*SW +: SW] <= {SW{1'b0}};
                end else if (zero_cross_source_select) begin
                    zx_sample_r[p*SW +: SW] <= raw_zx_data[p*SW +: SW];
                end else begin
                    zx_sample_r[p*SW +: SW] <= compensated_zx_data[p*SW +: SW];
                end
            end

            // apparent power voltage: nominal constant keeps the result steady
            // when the measured rms is unreliable, at the cost of accuracy
            always @(posedge clock) begin
                if (srst) begin
                    apparent_power_voltage_r[p*RW +: RW] <= {RW{1'b0}};
                end else if (vnom_sel[p]) begin
                    apparent_power_voltage_r[p*RW +: RW] <= nominal_voltage_constant;
                end else begin
                    apparent_power_voltage_r[p*RW +: RW] <= measured_voltage_rms[p*RW +: RW];
                end
            end

            // multipoint tracker per phase; it takes the enable straight from
            // ctrl_r so its off code lines up with the registered enable level
            mdc_mt_region #(
                .RW(RW),
                .GW(GW)
            ) u_mt (
                .clock(clock),
                .srst(srst),
                .enable(ctrl_r[`MDC_BIT_MT_EN]),
                .rms(current_rms_amplitude[p*RW +: RW]),
                .low_thr(multipoint_low_threshold[p*5*RW +: 5*RW]),
                .high_thr(multipoint_high_threshold[p*5*RW +: 5*RW]),
                .gain_tab(multipoint_gain_factor[p*6*GW +: 6*GW]),
                .region_r(multipoint_region_r[p*4 +: 4]),
                .gain_r(multipoint_gain_r[p*GW +: GW])
            );
        end
    endgenerate

endmodule

`default_nettype wire

/* File: verif/mdc_checker.sv */
// checker for the control register port, control levels, rms select and multipoint trackers of mdc_top
// assumes binding onto mdc_top, one clock, synchronous reset
`default_nettype none
`include "mdc_defines.vh"
module mdc_checker #(
    parameter SW = 24,
    parameter RW = 24,
    parameter GW = 24
) (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // host register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`MDC_ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata_r,
    input wire logic reg_rvalid_r,
    // current samples
    input wire logic [3*SW-1:0] raw_current,
    input wire logic [3*SW-1:0] compensated_current_waveform,
    input wire logic [18*GW-1:0] multipoint_gain_factor,
    // control levels and selects
    input wire logic reactive_power_lowpass_bypass,
    input wire logic active_power_lowpass_bypass,
    input wire logic neutral_integrator_enable,
    input wire logic phase_integrator_enable,
    input wire logic highpass_disable_all,
    input wire logic multipoint_compensation_enable,
    input wire logic [3*SW-1:0] rms_sample_r,
    input wire logic [3*GW-1:0] multipoint_gain_r,
    input wire logic [11:0] multipoint_region_r
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (srst);
    // write hit; effects land two edges later
    wire logic hit_w = reg_wr && reg_addr == `MDC_CTRL_OFFSET;
    property p_lpf;
        hit_w |=> ##1 {reactive_power_lowpass_bypass, active_power_lowpass_bypass}
            == $past(reg_wdata[13:12], 2);
    endproperty
    a_lpf: assert property (p_lpf) else $error("lowpass bypass mismatch");
    property p_int;
        hit_w |=> ##1 {neutral_integrator_enable, phase_integrator_enable}
            == {$past(reg_wdata[11], 2), $past(reg_wdata[5], 2)};
    endproperty
    a_int: assert property (p_int) else $error("integrator enable mismatch");
    property p_cfg;
        hit_w |=> ##1 {multipoint_compensation_enable, highpass_disable_all}
            == $past(reg_wdata[4:3], 2);
    endproperty
    a_cfg: assert property (p_cfg) else $error("multipoint or highpass mismatch");
    property p_rms;
        hit_w |=> ##1 rms_sample_r == ($past(reg_wdata[7], 2) ? $past(raw_current)
            : $past(compensated_current_waveform));
    endproperty
    a_rms: assert property (p_rms) else $error("rms source mismatch");
    // readback of a write, reserved bits zero
    property p_rback;
        hit_w ##1 (reg_rd && reg_addr == `MDC_CTRL_OFFSET)
            |=> reg_rdata_r == ($past(reg_wdata, 2) & `MDC_CTRL_WMASK);
    endproperty
    a_rback: assert property (p_rback) else $error("readback mismatch");
    property p_rd;
        reg_rd |=> reg_rvalid_r;
    endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    // off for two edges gives the disabled code on every phase
    property p_mtoff;
        !multipoint_compensation_enable [*2] |-> multipoint_region_r == 12'hFFF
            && multipoint_gain_r == '0;
    endproperty
    a_mtoff: assert property (p_mtoff) else $error("multipoint not idle");
    property p_mtrng;
        multipoint_compensation_enable [*2] |-> multipoint_region_r[3:0] <= 4'h5
            && multipoint_region_r[7:4] <= 4'h5 && multipoint_region_r[11:8] <= 4'h5;
    endproperty
    a_mtrng: assert property (p_mtrng) else $error("region out of six");
    // gain table as the trackers sampled it one edge back
    logic [18*GW-1:0] gain_tab_q;
    always_ff @(posedge clock) gain_tab_q <= multipoint_gain_factor;
    property p_mtgain;
        multipoint_compensation_enable |-> multipoint_gain_r[GW-1:0]
            == gain_tab_q[multipoint_region_r[3:0]*GW +: GW];
    endproperty
    a_mtgain: assert property (p_mtgain) else $error("gain not from region");
    c_wr: cover property (hit_w);
    c_mt: cover property (multipoint_compensation_enable [*2]);
    c_rd: cover property (reg_rvalid_r);
endmodule
bind mdc_top mdc_checker #(.SW(SW), .RW(RW), .GW(GW)) u_mdc_checker (.*);
`default_nettype wire

/* File: verif/test_metering_datapath_control.sv */
// self-checking bench for mdc_top with default widths
// assumes the checker is bound beside the design
`default_nettype none
`include "mdc_defines.vh"
module test_metering_datapath_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0, v;
    logic [23:0] nominal_voltage_constant = '0;
    logic [71:0] raw_current = '0, compensated_current_waveform = '0, raw_zx_data = '0;
    logic [71:0] compensated_zx_data = '0, measured_voltage_rms = '0, current_rms_amplitude = '0;
    logic [71:0] s_rms, s_zx, s_av;
    logic [359:0] multipoint_low_threshold = '0, multipoint_high_threshold = '0;
    logic [431:0] multipoint_gain_factor = '0;
    logic [5:0] g6;
    logic [31:0] m_ctrl;
    logic [8:0] m_idx, m_nx;
    logic [11:0] m_region;
    logic [71:0] m_gain;
    int err_total = 0, n_compared = 0, cyc = 0;
    wire logic [31:0] reg_rdata_r;
    wire logic reg_rvalid_r, reactive_power_lowpass_bypass, active_power_lowpass_bypass;
    wire logic neutral_integrator_enable, phase_integrator_enable, highpass_disable_all;
    wire logic multipoint_compensation_enable;
    wire logic [71:0] rms_sample_r, zx_sample_r, apparent_power_voltage_r, multipoint_gain_r;
    wire logic [11:0] multipoint_region_r;
    mdc_top u_mdc_top (.*);
    always #2 clock = ~clock;
    function automatic logic [71:0] r72();
        logic [95:0] t;
        t = {$urandom, $urandom, $urandom};
        return t[71:0];
    endfunction
    // fresh samples each cycle so a stale select shows up
    always @(posedge clock) begin
        raw_current <= r72();
        compensated_current_waveform <= r72();
        raw_zx_data <= r72();
        compensated_zx_data <= r72();
        measured_voltage_rms <= r72();
        current_rms_amplitude <= r72();
        nominal_voltage_constant <= 24'(r72());
        multipoint_low_threshold <= {5{r72()}};
        multipoint_high_threshold <= {5{r72()}};
        multipoint_gain_factor <= {6{r72()}};
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            tally_and_finish;
        end
    end
    // expected next region index: one step per edge, low/high hysteresis
    function automatic logic [2:0] mt_step(input logic [2:0] i, input logic en,
            input logic [23:0] r, input logic [119:0] lo, input logic [119:0] hi);
        if (!en) return 3'h0;
        if (i < 3'h5 && r > hi[i*24 +: 24]) return i + 3'h1;
        if (i > 3'h0 && r < lo[(i-3'h1)*24 +: 24]) return i - 3'h1;
        return i;
    endfunction
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            m_nx[p*3 +: 3] = mt_step(m_idx[p*3 +: 3], m_ctrl[`MDC_BIT_MT_EN],
                current_rms_amplitude[p*24 +: 24], multipoint_low_threshold[p*120 +: 120],
                multipoint_high_threshold[p*120 +: 120]);
        end
    end
    // reference trackers, fed what the design samples at each edge
    always @(posedge clock) begin
        if (srst) begin
            m_ctrl <= `MDC_CTRL_RESET;
            m_idx <= 9'h000;
            m_region <= 12'hFFF;
            m_gain <= 72'h0;
        end else begin
            if (reg_wr && reg_addr == `MDC_CTRL_OFFSET) begin
                m_ctrl <= reg_wdata & `MDC_CTRL_WMASK;
            end
            m_idx <= m_nx;
            for (int p = 0; p < 3; p++) begin
                m_region[p*4 +: 4] <= m_ctrl[`MDC_BIT_MT_EN] ?
                    {1'b0, m_nx[p*3 +: 3]} : `MDC_MT_OFF_CODE;
                m_gain[p*24 +: 24] <= m_ctrl[`MDC_BIT_MT_EN] ?
                    multipoint_gain_factor[(p*6+m_nx[p*3 +: 3])*24 +: 24] : 24'h0;
            end
        end
    end
    task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_dp(input string n, input logic [71:0] e, input logic [71:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        // the answer stands only in the cycle after the strobe edge
        #1;
        chk_reg("rvalid", 32'h1, {31'h0, reg_rvalid_r});
        chk_reg("rdata", e, reg_rdata_r);
        @(posedge clock);
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        v = $urandom(32'hED53EF01);
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rd(12'h060, 32'h0);
        // first two passes are the all-zero and all-one corners
        for (int i = 0; i < 40; i++) begin
            v = (i < 2) ? {32{i[0]}} : $urandom;
            wr(12'h060, v);
            rd(12'h060, v & `MDC_CTRL_WMASK);
            wr(12'h061, ~v);
            rd(12'h061, 32'h0);
            @(posedge clock);
            s_rms = v[7] ? raw_current : compensated_current_waveform;
            s_zx = v[6] ? raw_zx_data : compensated_zx_data;
            for (int p = 0; p < 3; p++) begin
                s_av[p*24 +: 24] = v[8+p] ? nominal_voltage_constant : measured_voltage_rms[p*24 +: 24];
            end
            #1;
            g6 = {reactive_power_lowpass_bypass, active_power_lowpass_bypass,
                neutral_integrator_enable, phase_integrator_enable,
                multipoint_compensation_enable, highpass_disable_all};
            chk_dp("ctl", {66'h0, v[13:11], v[5:3]}, {66'h0, g6});
            chk_dp("rms_sample", s_rms, rms_sample_r);
            chk_dp("zx_sample", s_zx, zx_sample_r);
            chk_dp("app_volt", s_av, apparent_power_voltage_r);
            chk_dp("mt_region", {60'h0, m_region}, {60'h0, multipoint_region_r});
            chk_dp("mt_gain", m_gain, multipoint_gain_r);
            @(posedge clock);
        end
        tally_and_finish;
    end
endmodule
`default_nettype wire
